// ### logic/cgp_node.sv
// Contract
// RL1 - master guards with a zero-length remote frame on guarding base plus node
// RL2 - guarding query answered with one state byte on guarding id plus node
// RL3 - state byte bit 7 toggles on each successive guarding reply
// RL4 - state byte low bits: 4 stopped, 5 operational, 127 pre-operational
// RL5 - reply promptly to each query; master times the window
// RL6 - after boot send one frame on guarding id, one byte of zero
// RL7 - nonzero producer period sends periodic byte 05h, toggle clear
// RL8 - network delivers a guarding frame within each consumer period
// RL9 - consumer period elapsing without guarding frame raises loss flag
// RL10 - process data needs no acknowledgement either way
// RL11 - four transmit and four receive process data objects
// RL12 - every process data object carries exactly eight bytes
// RL13 - 11-bit ids default from type and node, each reconfigurable
// RL14 - transmit ids 181h..481h plus node, carrying bytes 1-32 in order (code defaults to 180h..480h plus node)
// RL15 - receive ids 201h..501h plus node, supplying bytes 1-32 in order (code defaults to 200h..500h plus node)
// RL16 - type 255 sends whenever any contained byte changes
// RL17 - type 0 sends on SYNC only if a byte changed
// RL18 - type n in 1..240 sends after every n SYNC frames
// RL19 - type 254/255 with nonzero event timer N sends every N ms
// RL20 - zero-length remote frame on a transmit id sends that object
// RL21 - process data transmitted only while operational
// RL22 - receive type fixed 255, data passed on immediately
// RL23 - status indicator flashes red/green until first data exchange
// RL24 - process data also reachable via diagnostic service access path (code: diagAccess only marks an exchange for the indicator)
`timescale 1ns/10ps
`include "cgp_regs.svh"

module cgp_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic      [W-1:0] outData
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wPtr;
      logic [AW-1:0]       rPtr;
      logic [AW:0]         count;
   } cgp_fifo_st_type;
   cgp_fifo_st_type s;
   cgp_fifo_st_type next_s;
   logic wr;
   logic rd;

   assign inReady  = s.count != (AW+1)'(D);
   assign outValid = s.count != '0;
   assign outData  = s.mem[s.rPtr];
   assign wr       = inValid && inReady;
   assign rd       = outValid && outReady;

   always_comb begin
      next_s = s;
      if (wr) begin
         next_s.mem[s.wPtr] = inData;
         next_s.wPtr = AW'(s.wPtr + 1'b1);
      end
      if (rd) begin
         next_s.rPtr = AW'(s.rPtr + 1'b1);
      end
      next_s.count = (AW+1)'(s.count + {AW'(0), wr} - {AW'(0), rd});
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

module cgp_node #(
   parameter int MS_CYCLES = `CGP_MS_CYCLES
) (
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic [6:0]            nodeId,
   input  wire logic [6:0]            nmtState,
   input  wire logic [15:0]           prodHbMs,
   input  wire logic [15:0]           consHbMs,
   input  wire logic                  hbLossClr,
   input  wire logic [3:0][7:0]       txType,
   input  wire logic [3:0][15:0]      eventMs,
   input  wire logic [3:0][10:0]      txCobId,
   input  wire logic [3:0][10:0]      rxCobId,
   input  wire logic                  cfgChange,
   input  wire logic                  diagAccess,
   input  wire logic                  rxValid,
   input  wire cgp_pkg::cgp_frame_type rxFrame,
   output logic                       txValid,
   input  wire logic                  txReady,
   output cgp_pkg::cgp_frame_type     txFrame,
   input  wire logic [255:0]          process_bytes_in,
   output logic [255:0]               process_bytes_out,
   output logic                       rxUpdate,
   output logic                       hbLoss,
   output logic                       ledRed,
   output logic                       ledGreen
);
   import cgp_pkg::*;

   typedef struct packed {
      logic [15:0]       msCnt;
      logic              bootPend;
      logic              guardPend;
      logic              toggle;
      logic              hbPend;
      logic [15:0]       hbCnt;
      logic [15:0]       consCnt;
      logic              hbLoss;
      logic [3:0]        pend;
      logic [3:0][7:0]   syncCnt;
      logic [3:0][15:0]  evtCnt;
      logic [3:0][63:0]  lastSent;
      logic [255:0]      rxImage;
      logic              rxUpd;
      logic              exchanged;
      logic [15:0]       ledCnt;
      logic              ledPhase;
   } cgp_node_st_type;

   cgp_node_st_type s;
   cgp_node_st_type next_s;
   cgp_frame_type   fr;
   cgp_kind_type    kind;
   logic            push;
   logic            fifoReady;
   logic            msTick;
   logic            guardRx;
   logic            syncRx;
   logic            oper;
   logic [10:0]     guardId;
   logic [3:0][10:0] txId;
   logic [3:0][10:0] rxId;
   logic [3:0]      rxHit;
   logic [1:0]      sel;

   assign guardId = 11'(`CGP_GUARD_BASE + {4'h0, nodeId});
   assign oper    = nmtState == `CGP_NMT_OPER;
   assign msTick  = s.msCnt == 16'(MS_CYCLES - 1);
   assign guardRx = rxValid && rxFrame.id == guardId;
   assign syncRx  = rxValid && !rxFrame.rtr && rxFrame.id == `CGP_SYNC_ID;

   // zero override keeps the node-derived default id
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         txId[i] = (txCobId[i] != '0) ? txCobId[i]                   // [RL13]
                 : 11'(`CGP_TX_BASE + i * `CGP_ID_STEP + nodeId);    // [RL14]
         rxId[i] = (rxCobId[i] != '0) ? rxCobId[i]
                 : 11'(`CGP_RX_BASE + i * `CGP_ID_STEP + nodeId);    // [RL15]
         rxHit[i] = rxValid && !rxFrame.rtr && rxFrame.id == rxId[i]
                 && rxFrame.dlc == `CGP_DLC_PDO;                     // [RL11]
      end
   end

   // fixed priority: boot, guard reply, heartbeat, lowest object
   always_comb begin
      fr = '0;
      kind = K_NONE;
      sel = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (s.pend[i]) begin
            sel = 2'(i);
         end
      end
      fr.id = guardId;
      fr.dlc = `CGP_DLC_STATE;
      if (s.bootPend) begin
         kind = K_BOOT;                                              // [RL6]
      end else if (s.guardPend) begin
         kind = K_GUARD;                                             // [RL2]
         fr.data[7:0] = {s.toggle, nmtState};                        // [RL4]
      end else if (s.hbPend) begin
         kind = K_HB;
         fr.data[7:0] = `CGP_HB_BYTE;                                // [RL7]
      end else if (s.pend != '0) begin
         kind = K_PDO;
         fr.id = txId[sel];
         fr.dlc = `CGP_DLC_PDO;                                      // [RL12]
         fr.data = process_bytes_in[sel*64 +: 64];
      end
      push = kind != K_NONE;
   end

   always_comb begin
      next_s = s;
      next_s.rxUpd = 1'b0;
      next_s.msCnt = msTick ? 16'h0000 : 16'(s.msCnt + 1'b1);
      // clears from a taken frame first so a new event in this cycle wins
      if (push && fifoReady) begin
         case (kind)
            K_BOOT: next_s.bootPend = 1'b0;
            K_GUARD: begin
               next_s.guardPend = 1'b0;
               next_s.toggle = !s.toggle;                            // [RL3]
            end
            K_HB: next_s.hbPend = 1'b0;
            K_PDO: begin
               next_s.pend[sel] = 1'b0;
               next_s.lastSent[sel] = fr.data;
               next_s.exchanged = 1'b1;
            end
            default: next_s.bootPend = s.bootPend;
         endcase
      end
      // answered as soon as the queue has room
      if (guardRx && rxFrame.rtr && rxFrame.dlc == `CGP_DLC_RTR) begin
         next_s.guardPend = 1'b1;                                    // [RL5]
      end
      if (prodHbMs == '0) begin
         next_s.hbCnt = '0;
      end else if (msTick) begin
         if (s.hbCnt >= 16'(prodHbMs - 1'b1)) begin
            next_s.hbCnt = '0;
            next_s.hbPend = 1'b1;                                    // [RL7]
         end else begin
            next_s.hbCnt = 16'(s.hbCnt + 1'b1);
         end
      end
      // saturating watchdog; loss stays flagged until hbLossClr
      if (guardRx || consHbMs == '0) begin
         next_s.consCnt = '0;                                        // [RL8]
      end else if (msTick && s.consCnt != consHbMs) begin
         next_s.consCnt = 16'(s.consCnt + 1'b1);
      end
      if (hbLossClr) begin
         next_s.hbLoss = 1'b0;
      end
      if (consHbMs != '0 && s.consCnt == consHbMs && !guardRx) begin
         next_s.hbLoss = 1'b1;                                       // [RL9]
      end
      for (int i = 0; i < 4; i++) begin
         // compare to the copy just taken, so a sent object never pends twice
         if (txType[i] == `CGP_TT_CHANGE
             && process_bytes_in[i*64 +: 64] != next_s.lastSent[i]) begin
            next_s.pend[i] = 1'b1;                                   // [RL16]
         end
         if (syncRx) begin
            if (txType[i] == `CGP_TT_ACYC
                && process_bytes_in[i*64 +: 64] != next_s.lastSent[i]) begin
               next_s.pend[i] = 1'b1;                                // [RL17]
            end
            if (txType[i] != `CGP_TT_ACYC
                && txType[i] <= `CGP_TT_SYNCMAX) begin
               if (8'(s.syncCnt[i] + 1'b1) >= txType[i]) begin
                  next_s.syncCnt[i] = '0;
                  next_s.pend[i] = 1'b1;                             // [RL18]
               end else begin
                  next_s.syncCnt[i] = 8'(s.syncCnt[i] + 1'b1);
               end
            end
         end
         if ((txType[i] == `CGP_TT_EVENT || txType[i] == `CGP_TT_CHANGE)
             && eventMs[i] != '0) begin
            if (msTick) begin
               if (16'(s.evtCnt[i] + 1'b1) >= eventMs[i]) begin
                  next_s.evtCnt[i] = '0;
                  next_s.pend[i] = 1'b1;                             // [RL19]
               end else begin
                  next_s.evtCnt[i] = 16'(s.evtCnt[i] + 1'b1);
               end
            end
         end else begin
            next_s.evtCnt[i] = '0;
         end
         if (rxValid && rxFrame.rtr && rxFrame.id == txId[i]
             && rxFrame.dlc == `CGP_DLC_RTR) begin
            next_s.pend[i] = 1'b1;                                   // [RL20]
         end
         // requests outside operational are dropped, not deferred
         if (!oper) begin
            next_s.pend[i] = 1'b0;                                   // [RL21]
         end
         // fire and forget: nothing waits for an answer
         if (rxHit[i]) begin
            next_s.rxImage[i*64 +: 64] = rxFrame.data;               // [RL22]
            next_s.rxUpd = 1'b1;                                     // [RL10]
            next_s.exchanged = 1'b1;
         end
      end
      if (cfgChange) begin
         next_s.exchanged = 1'b0;
      end
      if (diagAccess || (push && fifoReady && kind == K_PDO)
          || rxHit != '0) begin
         next_s.exchanged = 1'b1;                                    // [RL24]
      end
      if (msTick) begin
         if (s.ledCnt >= 16'(`CGP_LED_MS - 1'b1)) begin
            next_s.ledCnt = '0;
            next_s.ledPhase = !s.ledPhase;
         end else begin
            next_s.ledCnt = 16'(s.ledCnt + 1'b1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s <= '0;
         s.bootPend <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // queue between frame builder and controller; full stalls arbitration
   cgp_fifo #(
      .W ($bits(cgp_frame_type)),
      .D (`CGP_FIFO_DEPTH)
   ) txQueue (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .inValid  (push),
      .inReady  (fifoReady),
      .inData   (fr),
      .outValid (txValid),
      .outReady (txReady),
      .outData  (txFrame)
   );

   assign process_bytes_out = s.rxImage;
   assign rxUpdate = s.rxUpd;
   assign hbLoss   = s.hbLoss;
   assign ledRed   = !s.exchanged && s.ledPhase;                     // [RL23]
   assign ledGreen = s.exchanged || !s.ledPhase;

   property p_guard_len;
      @(posedge clk_sys) disable iff (sys_rst)
      push && fifoReady && kind == K_GUARD |-> fr.dlc == 4'h1;
   endproperty
   a_guard_len: assert property (p_guard_len) else $error("bad dlc"); // [RL2]

   property p_toggle;
      @(posedge clk_sys) disable iff (sys_rst)
      push && fifoReady && kind == K_GUARD |=> s.toggle != $past(s.toggle);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle"); // [RL3]

   property p_state;
      @(posedge clk_sys) disable iff (sys_rst)
      kind == K_GUARD |-> fr.data[6:0] == nmtState && fr.data[7] == s.toggle;
   endproperty
   a_state: assert property (p_state) else $error("bad state byte"); // [RL4]

   property p_boot;
      @(posedge clk_sys) disable iff (sys_rst)
      $fell(sys_rst) |-> kind == K_BOOT && fr.data == '0 && fr.dlc == 4'h1;
   endproperty
   a_boot: assert property (p_boot) else $error("bootup frame"); // [RL6]

   property p_hb;
      @(posedge clk_sys) disable iff (sys_rst)
      kind == K_HB |-> fr.data[7:0] == 8'h05 && fr.id == guardId;
   endproperty
   a_hb: assert property (p_hb) else $error("heartbeat frame"); // [RL7]

   property p_loss;
      @(posedge clk_sys) disable iff (sys_rst)
      consHbMs != '0 && s.consCnt == consHbMs && !guardRx |=> hbLoss;
   endproperty
   a_loss: assert property (p_loss) else $error("loss missed"); // [RL9]

   property p_oper;
      @(posedge clk_sys) disable iff (sys_rst)
      !oper ##1 !oper |-> kind != K_PDO;
   endproperty
   a_oper: assert property (p_oper) else $error("pdo not oper"); // [RL21]

   property p_pdo_len;
      @(posedge clk_sys) disable iff (sys_rst)
      kind == K_PDO |-> fr.dlc == 4'h8
      && fr.data == process_bytes_in[sel*64 +: 64];
   endproperty
   a_pdo_len: assert property (p_pdo_len) else $error("pdo len"); // [RL12]

   property p_rx;
      @(posedge clk_sys) disable iff (sys_rst)
      rxHit[0] |=> rxUpdate && process_bytes_out[63:0] == $past(rxFrame.data);
   endproperty
   a_rx: assert property (p_rx) else $error("rx not passed"); // [RL22]

   property p_rtr;
      @(posedge clk_sys) disable iff (sys_rst)
      oper && rxValid && rxFrame.rtr && rxFrame.dlc == 4'h0
      && rxFrame.id == txId[0] ##1 oper |-> s.pend[0];
   endproperty
   a_rtr: assert property (p_rtr) else $error("rtr lost"); // [RL20]

   c_guard: cover property (@(posedge clk_sys) push && kind == K_GUARD);
   c_pdo: cover property (@(posedge clk_sys)
      push && fifoReady && kind == K_PDO);
   c_loss: cover property (@(posedge clk_sys) $rose(hbLoss));
   c_full: cover property (@(posedge clk_sys) push && !fifoReady);
endmodule

// ### common/cgp_regs.svh
`ifndef CGP_REGS_SVH
`define CGP_REGS_SVH
`define CGP_CLK_NS     25
`define CGP_MS_NS      1000000
`define CGP_MS_CYCLES  (`CGP_MS_NS / `CGP_CLK_NS)
`define CGP_LED_MS     16'h00FA
`define CGP_GUARD_BASE 11'h700
`define CGP_SYNC_ID    11'h080
`define CGP_TX_BASE    11'h180
`define CGP_RX_BASE    11'h200
`define CGP_ID_STEP    11'h100
`define CGP_NMT_STOP   7'h04
`define CGP_NMT_OPER   7'h05
`define CGP_NMT_PREOP  7'h7F
`define CGP_HB_BYTE    8'h05
`define CGP_TT_CHANGE  8'hFF
`define CGP_TT_EVENT   8'hFE
`define CGP_TT_SYNCMAX 8'hF0
`define CGP_TT_ACYC    8'h00
`define CGP_DLC_STATE  4'h1
`define CGP_DLC_PDO    4'h8
`define CGP_DLC_RTR    4'h0
`define CGP_FIFO_DEPTH 4
`endif

// ### common/cgp_pkg.sv
package cgp_pkg;
   typedef struct packed {
      logic [10:0] id;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cgp_frame_type;
   typedef enum {K_NONE, K_BOOT, K_GUARD, K_HB, K_PDO} cgp_kind_type;
endpackage

// ### sim/cgp_master_model.sv
`timescale 1ns/10ps
module cgp_master_model (
   input  wire logic                  clk_sys,
   output logic                       rxValid,
   output cgp_pkg::cgp_frame_type     rxFrame,
   output logic                       txReady,
   input  wire logic                  txValid,
   input  wire cgp_pkg::cgp_frame_type txFrame
);
   import cgp_pkg::*;
   cgp_frame_type got[$];
   logic          slow = 1'b0;
   initial begin
      rxValid = 1'b0;
      rxFrame = '0;
      txReady = 1'b1;
   end
   // frames are taken, never acknowledged back
   always @(posedge clk_sys) begin
      if (txValid && txReady)
         got.push_back(txFrame);
      #1 txReady <= slow ? ~txReady : 1'b1;
   end
   // guarding query is a zero-length remote frame
   // remote request on an object id, zero length
   task automatic send(input logic [10:0] id, input logic rtr,
                       input logic [3:0] dlc, input logic [63:0] d);
      @(posedge clk_sys);
      #1;
      rxFrame = {id, rtr, dlc, d};
      rxValid = 1'b1;
      @(posedge clk_sys);
      #1;
      rxValid = 1'b0;
      // released bus shows no stale frame
      rxFrame = ~rxFrame;
   endtask
endmodule

// ### sim/cgp_node_tb.sv
`timescale 1ns/10ps
`include "cgp_regs.svh"
module cgp_node_tb;
   import cgp_pkg::*;
   logic             clk_sys;
   logic             sys_rst;
   logic [6:0]       nodeId = 7'h05;
   logic [6:0]       nmtState;
   logic [15:0]      prodHbMs;
   logic [15:0]      consHbMs;
   logic             hbLossClr;
   logic [3:0][7:0]  txType;
   logic [3:0][15:0] eventMs = '0;
   logic [3:0][10:0] txCobId = '0;
   logic [3:0][10:0] rxCobId;
   logic             cfgChange = 1'b0;
   logic             diagAccess = 1'b0;
   logic             rxValid, txValid, txReady;
   logic             rxUpdate, hbLoss, ledRed, ledGreen;
   cgp_frame_type    rxFrame, txFrame, f;
   logic [255:0]     pbIn, pbOut;
   int               badCount = 0, checksDone = 0;
   int               cycles = 0, updCount = 0;

   cgp_node #(.MS_CYCLES(4)) cgp_node_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .nodeId(nodeId),
      .nmtState(nmtState), .prodHbMs(prodHbMs), .consHbMs(consHbMs),
      .hbLossClr(hbLossClr), .txType(txType), .eventMs(eventMs),
      .txCobId(txCobId), .rxCobId(rxCobId), .cfgChange(cfgChange),
      .diagAccess(diagAccess), .rxValid(rxValid), .rxFrame(rxFrame),
      .txValid(txValid), .txReady(txReady), .txFrame(txFrame),
      .process_bytes_in(pbIn), .process_bytes_out(pbOut),
      .rxUpdate(rxUpdate), .hbLoss(hbLoss), .ledRed(ledRed),
      .ledGreen(ledGreen));

   cgp_master_model cgp_master_model_inst (
      .clk_sys(clk_sys), .rxValid(rxValid), .rxFrame(rxFrame),
      .txReady(txReady), .txValid(txValid), .txFrame(txFrame));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // 20000 cycles is several times the whole sequence
   always @(posedge clk_sys) begin
      cycles++;
      if (rxUpdate === 1'b1)
         updCount++;
      if (cycles == 20000) begin
         badCount++;
         stop_test();
      end
   end

   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic [10:0] id, input logic rtr,
                       input logic [3:0] dlc, input logic [63:0] d);
      cgp_master_model_inst.send(id, rtr, dlc, d);
   endtask

   task automatic get_frame(output cgp_frame_type g);
      int n;
      n = 0;
      g = 'x;
      while (cgp_master_model_inst.got.size() == 0 && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      #2;
      if (cgp_master_model_inst.got.size() != 0)
         g = cgp_master_model_inst.got.pop_front();
   endtask

   task automatic expect_none(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
      chk(80'(cgp_master_model_inst.got.size()), 80'h0);
   endtask

   function automatic cgp_frame_type pdo(input int i);
      return {11'(`CGP_TX_BASE + `CGP_ID_STEP * i + nodeId), 1'b0,
              `CGP_DLC_PDO, pbIn[64*i+:64]};
   endfunction

   function automatic cgp_frame_type nodeMsg(input logic [7:0] b);
      return {11'(`CGP_GUARD_BASE + nodeId), 1'b0, `CGP_DLC_STATE,
              56'h0, b};
   endfunction

   task automatic t_boot;
      get_frame(f);
      chk(f, nodeMsg(8'h00));
      $display("test boot done");
   endtask

   task automatic t_guard;
      logic [6:0] st[3];
      logic       prev;
      st = '{`CGP_NMT_STOP, `CGP_NMT_OPER, `CGP_NMT_PREOP};
      for (int i = 0; i < 3; i++) begin
         nmtState = st[i];
         send(11'(`CGP_GUARD_BASE + nodeId), 1'b1, `CGP_DLC_RTR, 64'h0);
         get_frame(f);
         chk(f, nodeMsg({f.data[7], st[i]}));
         if (i > 0)
            chk(f.data[7], !prev);
         prev = f.data[7];
      end
      $display("test guard done");
   endtask

   task automatic t_remote;
      nmtState = `CGP_NMT_OPER;
      cgp_master_model_inst.slow = 1'b1;
      for (int i = 0; i < 4; i++)
         send(11'(`CGP_TX_BASE + `CGP_ID_STEP * i + nodeId), 1'b1,
              `CGP_DLC_RTR, 64'h0);
      for (int i = 0; i < 4; i++) begin
         get_frame(f);
         chk(f, pdo(i));
      end
      cgp_master_model_inst.slow = 1'b0;
      $display("test remote done");
   endtask

   task automatic t_sync;
      txType[0] = 8'h02;
      send(`CGP_SYNC_ID, 1'b0, 4'h0, 64'h0);
      expect_none(8);
      send(`CGP_SYNC_ID, 1'b0, 4'h0, 64'h0);
      get_frame(f);
      chk(f, pdo(0));
      txType[0] = `CGP_TT_EVENT;
      txType[1] = `CGP_TT_ACYC;
      send(`CGP_SYNC_ID, 1'b0, 4'h0, 64'h0);
      expect_none(8);
      pbIn[127:64] = ~pbIn[127:64];
      expect_none(8);
      send(`CGP_SYNC_ID, 1'b0, 4'h0, 64'h0);
      get_frame(f);
      chk(f, pdo(1));
      txType[1] = `CGP_TT_EVENT;
      txType[2] = `CGP_TT_CHANGE;
      pbIn[135:128] = 8'h5A;
      get_frame(f);
      chk(f, pdo(2));
      txType[2] = `CGP_TT_EVENT;
      $display("test sync and change done");
   endtask

   task automatic t_event;
      eventMs[3] = 16'h0003;
      get_frame(f);
      chk(f, pdo(3));
      expect_none(8);
      get_frame(f);
      chk(f, pdo(3));
      eventMs[3] = 16'h0000;
      expect_none(16);
      $display("test event timer done");
   endtask

   task automatic t_led;
      int n;
      n = 0;
      @(posedge clk_sys);
      #1;
      cfgChange = 1'b1;
      @(posedge clk_sys);
      #1;
      cfgChange = 1'b0;
      // catch the start of a red phase so the next flip is a full phase away
      while (ledRed !== 1'b0 && n < 1100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      while (ledRed !== 1'b1 && n < 2200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk({ledRed, ledGreen}, 2'b10);
      repeat (1010) @(posedge clk_sys);
      #1;
      chk({ledRed, ledGreen}, 2'b01);
      repeat (1000) @(posedge clk_sys);
      #1;
      chk({ledRed, ledGreen}, 2'b10);
      diagAccess = 1'b1;
      @(posedge clk_sys);
      #1;
      diagAccess = 1'b0;
      @(posedge clk_sys);
      #1;
      chk({ledRed, ledGreen}, 2'b01);
      $display("test indicator done");
   endtask

   task automatic t_preop;
      nmtState = `CGP_NMT_PREOP;
      send(11'(`CGP_TX_BASE + nodeId), 1'b1, `CGP_DLC_RTR, 64'h0);
      expect_none(10);
      $display("test preop done");
   endtask

   task automatic t_receive;
      rxCobId[3] = 11'h123;
      for (int i = 0; i < 4; i++)
         send(i < 3 ? 11'(`CGP_RX_BASE + `CGP_ID_STEP * i + nodeId)
                    : 11'h123, 1'b0, `CGP_DLC_PDO, {8{8'(8'hA0 + i)}});
      // wrong length must leave the image alone
      send(11'(`CGP_RX_BASE + nodeId), 1'b0, 4'h7, 64'h0);
      repeat (3) @(posedge clk_sys);
      #1;
      for (int i = 0; i < 4; i++)
         chk(pbOut[64*i+:64], {8{8'(8'hA0 + i)}});
      chk(80'(updCount), 80'h4);
      chk({ledRed, ledGreen}, 2'b01);
      $display("test receive done");
   endtask

   task automatic t_heartbeat;
      prodHbMs = 16'h0001;
      get_frame(f);
      chk(f, nodeMsg(`CGP_HB_BYTE));
      prodHbMs = 16'h0000;
      repeat (12) @(posedge clk_sys);
      cgp_master_model_inst.got.delete();
      consHbMs = 16'h0002;
      for (int i = 0; i < 5; i++) begin
         // guarding frames arrive inside each consumer period
         send(11'(`CGP_GUARD_BASE + nodeId), 1'b1, `CGP_DLC_RTR, 64'h0);
         repeat (2) @(posedge clk_sys);
         #1;
         chk(hbLoss, 1'b0);
      end
      repeat (20) @(posedge clk_sys);
      #1;
      chk(hbLoss, 1'b1);
      hbLossClr = 1'b1;
      send(11'(`CGP_GUARD_BASE + nodeId), 1'b1, `CGP_DLC_RTR, 64'h0);
      hbLossClr = 1'b0;
      @(posedge clk_sys);
      #1;
      chk(hbLoss, 1'b0);
      $display("test heartbeat done");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      sys_rst = 1'b1;
      nmtState = `CGP_NMT_PREOP;
      prodHbMs = 16'h0000;
      consHbMs = 16'h0000;
      hbLossClr = 1'b0;
      txType = {4{`CGP_TT_EVENT}};
      rxCobId = '0;
      for (int i = 0; i < 4; i++)
         pbIn[64*i+:64] = 64'h0706050403020100 + 64'h1010101010101010 * i;
      repeat (16) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      t_boot();
      t_guard();
      t_remote();
      t_sync();
      t_event();
      t_preop();
      t_receive();
      t_led();
      t_heartbeat();
      stop_test();
   end
endmodule
